// ===== core/edcfg_map.svh
`ifndef EDCFG_MAP_SVH
`define EDCFG_MAP_SVH
// ==========================================
// register offsets
`define EDCFG_OFF_PWR      8'h00
`define EDCFG_OFF_INMODE   8'h01
`define EDCFG_OFF_OUTCOL   8'h02
`define EDCFG_OFF_SWRST    8'h17
`define EDCFG_OFF_STD      8'h30
`define EDCFG_OFF_PIXVAL   8'h31
`define EDCFG_OFF_INFMT    8'h33
`define EDCFG_OFF_INCOL    8'h35
// ==========================================
// decoded setting values
`define EDCFG_VAL_PWR_ED8X 8'h1c
`define EDCFG_VAL_DDR      8'h20
`define EDCFG_VAL_SDR      8'h10
`define EDCFG_VAL_RGBOUT   8'h10
`define EDCFG_VAL_STD_HV   8'h00
`define EDCFG_VAL_STD_EAV  8'h04
`define EDCFG_VAL_FMT_10   8'h6c
`define EDCFG_VAL_FMT_444  8'h2c
`define EDCFG_VAL_RGBIN    8'h02
`define EDCFG_VAL_SWRST    8'h02
`define EDCFG_VAL_PIXVAL   8'h01
// ==========================================
// reset value of every register
`define EDCFG_RST_VAL      8'h00
`endif

// ===== core/edcfg_pkg.sv
package edcfg_pkg;
  typedef enum logic [2:0] {
    EDCFG_RATE_NONE = 3'b001,
    EDCFG_RATE_SDR  = 3'b010,
    EDCFG_RATE_DDR  = 3'b100
  } edcfg_rate_t;
  typedef enum logic [2:0] {
    EDCFG_W_NONE = 3'b001,
    EDCFG_W_20   = 3'b010,
    EDCFG_W_30   = 3'b100
  } edcfg_width_t;
endpackage

// ===== core/edcfg_reg8.sv
`timescale 1ns/1ns
`include "edcfg_map.svh"
module edcfg_reg8
  import edcfg_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_clear,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_q
);
  // ==========================================
  // one storage byte, cleared by reset or by soft reset, which spares the register at 0x17
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst || i_clear)
      o_q <= `EDCFG_RST_VAL;
    else if (i_wr)
      o_q <= i_wdata;
  end
endmodule // edcfg_reg8

// ===== core/edcfg_decode.sv
`timescale 1ns/1ns
`include "edcfg_map.svh"
module edcfg_decode
  import edcfg_pkg::*;
(
  input  wire logic [7:0]   i_pwr,
  input  wire logic [7:0]   i_inmode,
  input  wire logic [7:0]   i_outcol,
  input  wire logic [7:0]   i_std,
  input  wire logic [7:0]   i_infmt,
  input  wire logic [7:0]   i_incol,
  output logic              o_ed_enable,
  output edcfg_rate_t       o_rate,
  output logic              o_rgb_out,
  output logic              o_sync_hv,
  output logic              o_sync_eav,
  output edcfg_width_t      o_width,
  output logic              o_rgb_in
);
  // ==========================================
  // setting decode
  assign o_ed_enable = (i_pwr == `EDCFG_VAL_PWR_ED8X);                    // [R1]
  assign o_rate = (i_inmode == `EDCFG_VAL_DDR) ? EDCFG_RATE_DDR :         // [R2]
                  (i_inmode == `EDCFG_VAL_SDR) ? EDCFG_RATE_SDR : EDCFG_RATE_NONE;
  assign o_rgb_out = (i_outcol == `EDCFG_VAL_RGBOUT);                     // [R3]
  assign o_sync_hv = (i_std == `EDCFG_VAL_STD_HV);                        // [R4]
  assign o_sync_eav = (i_std == `EDCFG_VAL_STD_EAV);                      // [R5]
  assign o_width = (i_infmt == `EDCFG_VAL_FMT_10)  ? EDCFG_W_20 :         // [R6]
                   (i_infmt == `EDCFG_VAL_FMT_444) ? EDCFG_W_30 : EDCFG_W_NONE; // [R7]
  assign o_rgb_in = (i_infmt == `EDCFG_VAL_FMT_444) &&
                    (i_incol == `EDCFG_VAL_RGBIN);                        // [R7]
endmodule // edcfg_decode

// ===== core/edcfg_bank.sv
// Function
// R1: 0x1C enables all DACs, PLL 8x
// R2: input mode 0x20 DDR, 0x10 SDR
// R3: output 0x10 gives RGB with sync
// R4: standard 0x00: 525p, HSYNC/VSYNC timing
// R5: standard 0x04: 525p, EAV/SAV timing
// R6: format 0x6C: 10-bit, 20-bit in SDR
// R7: format 0x2C 4:4:4; color 0x02 RGB
// R8: host soft-resets first, ends with pixel-valid
`timescale 1ns/1ns
`include "edcfg_map.svh"
module edcfg_bank
  import edcfg_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_dac_enable,
  output logic            o_pll_enable,
  output logic            o_pll_8x,
  output logic            o_ddr_mode,
  output logic            o_luma_falling_edge,
  output logic            o_sdr_mode,
  output logic            o_rgb_out,
  output logic            o_rgb_sync,
  output logic            o_std_525p,
  output logic            o_sync_hv,
  output logic            o_sync_eav,
  output logic            o_eia770_levels,
  output logic            o_pixel_valid,
  output logic            o_in_20bit,
  output logic            o_in_30bit_444,
  output logic            o_rgb_in
);
  // ==========================================
  // address decode
  localparam int NREG = 8;
  logic [7:0] reg_off [NREG];
  assign reg_off[0] = `EDCFG_OFF_PWR;
  assign reg_off[1] = `EDCFG_OFF_INMODE;
  assign reg_off[2] = `EDCFG_OFF_OUTCOL;
  assign reg_off[3] = `EDCFG_OFF_SWRST;
  assign reg_off[4] = `EDCFG_OFF_STD;
  assign reg_off[5] = `EDCFG_OFF_PIXVAL;
  assign reg_off[6] = `EDCFG_OFF_INFMT;
  assign reg_off[7] = `EDCFG_OFF_INCOL;

  logic [7:0] q [NREG];
  logic [NREG-1:0] hit;
  wire soft_rst = i_wr && (i_addr == `EDCFG_OFF_SWRST) &&
                  (i_wdata == `EDCFG_VAL_SWRST);                          // [R8]

  // ==========================================
  // register storage
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1)
    begin : g_reg
      assign hit[g] = (i_addr == reg_off[g]);
      edcfg_reg8 u_reg (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_clear   (soft_rst && (g != 3)),
        .i_wr      (i_wr && hit[g]),
        .i_wdata   (i_wdata),
        .o_q       (q[g])
      );
    end
  endgenerate

  // ==========================================
  // read mux, unmapped reads zero
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = 8'h00;
    for (int k = 0; k < NREG; k++)
      if (hit[k])
        next_rdata = q[k];
  end

  // ==========================================
  // setting decode
  logic         ed_en;
  edcfg_rate_t  rate;
  logic         rgb_o;
  logic         s_hv;
  logic         s_eav;
  edcfg_width_t wid;
  logic         rgb_i;
  edcfg_decode u_dec (
    .i_pwr       (q[0]),
    .i_inmode    (q[1]),
    .i_outcol    (q[2]),
    .i_std       (q[4]),
    .i_infmt     (q[6]),
    .i_incol     (q[7]),
    .o_ed_enable (ed_en),
    .o_rate      (rate),
    .o_rgb_out   (rgb_o),
    .o_sync_hv   (s_hv),
    .o_sync_eav  (s_eav),
    .o_width     (wid),
    .o_rgb_in    (rgb_i)
  );

  // ==========================================
  // next values of the registered outputs
  logic [7:0] next_rd_word;
  logic       next_dac_enable;
  logic       next_pll_enable;
  logic       next_pll_8x;
  logic       next_ddr_mode;
  logic       next_luma_falling_edge;
  logic       next_sdr_mode;
  logic       next_rgb_out;
  logic       next_rgb_sync;
  logic       next_std_525p;
  logic       next_sync_hv;
  logic       next_sync_eav;
  logic       next_eia770_levels;
  logic       next_pixel_valid;
  logic       next_in_20bit;
  logic       next_in_30bit_444;
  logic       next_rgb_in;

  assign next_rd_word           = i_rd ? next_rdata : 8'h00;
  assign next_dac_enable        = ed_en;                                  // [R1]
  assign next_pll_enable        = ed_en;                                  // [R1]
  assign next_pll_8x            = ed_en;                                  // [R1]
  assign next_ddr_mode          = (rate == EDCFG_RATE_DDR);               // [R2]
  assign next_luma_falling_edge = (rate == EDCFG_RATE_DDR);               // [R2]
  assign next_sdr_mode          = (rate == EDCFG_RATE_SDR);               // [R2]
  assign next_rgb_out           = rgb_o;                                  // [R3]
  assign next_rgb_sync          = rgb_o;                                  // [R3]
  assign next_std_525p          = s_hv || s_eav;                          // [R4] [R5]
  assign next_sync_hv           = s_hv;                                   // [R4]
  assign next_sync_eav          = s_eav;                                  // [R5]
  assign next_eia770_levels     = s_hv || s_eav;                          // [R4] [R5]
  assign next_pixel_valid       = (q[5] == `EDCFG_VAL_PIXVAL);            // [R8]
  assign next_in_20bit          = (wid == EDCFG_W_20) && (rate == EDCFG_RATE_SDR); // [R6]
  assign next_in_30bit_444      = (wid == EDCFG_W_30);                    // [R7]
  assign next_rgb_in            = rgb_i;                                  // [R7]

  // ==========================================
  // read data, one cycle after the read strobe
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_rdata <= 8'h00;
    else
      o_rdata <= next_rd_word;
  end

  // ==========================================
  // dac and pll enables
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_dac_enable <= 1'h0;
    else
      o_dac_enable <= next_dac_enable;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_pll_enable <= 1'h0;
    else
      o_pll_enable <= next_pll_enable;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_pll_8x <= 1'h0;
    else
      o_pll_8x <= next_pll_8x;
  end

  // ==========================================
  // input data rate
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_ddr_mode <= 1'h0;
    else
      o_ddr_mode <= next_ddr_mode;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_luma_falling_edge <= 1'h0;
    else
      o_luma_falling_edge <= next_luma_falling_edge;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_sdr_mode <= 1'h0;
    else
      o_sdr_mode <= next_sdr_mode;
  end

  // ==========================================
  // output colour space
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_rgb_out <= 1'h0;
    else
      o_rgb_out <= next_rgb_out;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_rgb_sync <= 1'h0;
    else
      o_rgb_sync <= next_rgb_sync;
  end

  // ==========================================
  // standard, sync source and levels
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_std_525p <= 1'h0;
    else
      o_std_525p <= next_std_525p;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_sync_hv <= 1'h0;
    else
      o_sync_hv <= next_sync_hv;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_sync_eav <= 1'h0;
    else
      o_sync_eav <= next_sync_eav;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_eia770_levels <= 1'h0;
    else
      o_eia770_levels <= next_eia770_levels;
  end

  // ==========================================
  // pixel valid and input format
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_pixel_valid <= 1'h0;
    else
      o_pixel_valid <= next_pixel_valid;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_in_20bit <= 1'h0;
    else
      o_in_20bit <= next_in_20bit;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_in_30bit_444 <= 1'h0;
    else
      o_in_30bit_444 <= next_in_30bit_444;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_rgb_in <= 1'h0;
    else
      o_rgb_in <= next_rgb_in;
  end
endmodule // edcfg_bank

// ===== verification/edcfg_bank_sva.sv
`timescale 1ns/1ns
// ====
// config bank checker
module edcfg_bank_sva (
  input wire logic       i_mclk, i_sys_rst, i_wr,
  input wire logic [7:0] i_addr, i_wdata,
  input wire logic       o_dac_enable, o_pll_enable, o_pll_8x, o_ddr_mode, o_sdr_mode,
  input wire logic       o_luma_falling_edge, o_rgb_out, o_rgb_sync, o_std_525p, o_sync_hv,
  input wire logic       o_sync_eav, o_eia770_levels, o_in_20bit, o_in_30bit_444, o_rgb_in,
  input wire logic       o_pixel_valid
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  a_pwr_decode: assert property (i_wr && i_addr == 8'h00 |-> ##2
    {o_dac_enable, o_pll_enable, o_pll_8x} == {3{$past(i_wdata, 2) == 8'h1c}})
    else $error("power decode wrong");
  a_rate_decode: assert property (i_wr && i_addr == 8'h01 |-> ##2
    o_ddr_mode == ($past(i_wdata, 2) == 8'h20) && o_luma_falling_edge == o_ddr_mode
    && o_sdr_mode == ($past(i_wdata, 2) == 8'h10)) else $error("rate decode wrong");
  a_rgb_out: assert property (i_wr && i_addr == 8'h02 |-> ##2
    {o_rgb_out, o_rgb_sync} == {2{$past(i_wdata, 2) == 8'h10}}) else $error("rgb out wrong");
  a_sync_hv: assert property (i_wr && i_addr == 8'h30 |-> ##2
    o_sync_hv == ($past(i_wdata, 2) == 8'h00) && o_eia770_levels == o_std_525p
    && o_std_525p == ($past(i_wdata, 2) inside {8'h00, 8'h04})) else $error("hv sync wrong");
  a_sync_eav: assert property (i_wr && i_addr == 8'h30 |-> ##2
    o_sync_eav == ($past(i_wdata, 2) == 8'h04)) else $error("eav sync wrong");
  a_width_20: assert property (i_wr && i_addr == 8'h33 |-> ##2
    o_in_20bit == ($past(i_wdata, 2) == 8'h6c && o_sdr_mode))
    else $error("20-bit decode wrong");
  a_fmt_444: assert property (i_wr && i_addr == 8'h33 |-> ##2
    o_in_30bit_444 == ($past(i_wdata, 2) == 8'h2c)) else $error("444 decode wrong");
  a_rgb_in: assert property (i_wr && i_addr == 8'h35 |-> ##2
    o_rgb_in == ($past(i_wdata, 2) == 8'h02 && o_in_30bit_444))
    else $error("rgb in decode wrong");
  a_pix_valid: assert property (i_wr && i_addr == 8'h31 |-> ##2
    o_pixel_valid == ($past(i_wdata, 2) == 8'h01)) else $error("pixel valid wrong");
endmodule // edcfg_bank_sva
bind edcfg_bank edcfg_bank_sva u_sva (.*);

// ===== verification/edcfg_host.sv
`timescale 1ns/1ns
// ====
// host controller model
module edcfg_host (
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_mclk,
  output logic      [7:0] o_addr, o_wdata,
  output logic            o_wr, o_rd
);
  initial {o_addr, o_wdata, o_wr, o_rd} = 18'h0;
  task automatic wr(input logic [7:0] a, d);
    @(posedge i_mclk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_mclk);
    o_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    #1 d = i_rdata;
  endtask
  task automatic script(input logic [7:0] p, m, o, s, f, c);
    wr(8'h17, 8'h02);
    wr(8'h00, p);
    wr(8'h01, m);
    wr(8'h02, o);
    wr(8'h30, s);
    wr(8'h33, f);
    wr(8'h35, c);
    wr(8'h31, 8'h01);
  endtask
endmodule // edcfg_host

// ===== verification/edcfg_bank_tb.sv
`timescale 1ns/1ns
module edcfg_bank_tb;
  logic i_mclk, i_sys_rst, i_wr, i_rd, o_dac_enable, o_pll_enable, o_pll_8x, o_ddr_mode;
  logic o_luma_falling_edge, o_sdr_mode, o_rgb_out, o_rgb_sync, o_std_525p, o_sync_hv;
  logic o_sync_eav, o_eia770_levels, o_pixel_valid, o_in_20bit, o_in_30bit_444, o_rgb_in;
  logic [7:0] i_addr, i_wdata, o_rdata, rv;
  int n_fail, compares;
  edcfg_bank u_dut (.*);
  edcfg_host u_host (.i_mclk(i_mclk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));
  wire logic [15:0] outs = {o_dac_enable, o_pll_enable, o_pll_8x, o_ddr_mode,
    o_luma_falling_edge, o_sdr_mode, o_rgb_out, o_rgb_sync, o_std_525p, o_sync_hv,
    o_sync_eav, o_eia770_levels, o_pixel_valid, o_in_20bit, o_in_30bit_444, o_rgb_in};
  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %0t: read %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic t_regs;
    logic [7:0] a [8] = '{8'h00, 8'h01, 8'h02, 8'h17, 8'h30, 8'h31, 8'h33, 8'h35};
    for (int i = 0; i < 8; i++)
    begin
      u_host.rd(a[i], rv);
      chk_rd(rv, 8'h00);
      u_host.wr(a[i], a[i] ^ 8'ha5);
      u_host.rd(a[i], rv);
      chk_rd(rv, a[i] ^ 8'ha5);
    end
    u_host.wr(8'h40, 8'h3c);
    u_host.rd(8'h40, rv);
    chk_rd(rv, 8'h00);
    u_host.wr(8'h17, 8'h02);
    u_host.rd(8'h35, rv);
    chk_rd(rv, 8'h00);
    u_host.rd(8'h17, rv);
    chk_rd(rv, 8'h02);
    $display("regs done");
  endtask
  task automatic t_scripts;
    logic [47:0] rows [6] = '{48'h1c20_0000_6c00, 48'h1c20_1004_6c00, 48'h1c10_1004_6c00,
      48'h1c10_0000_2c00, 48'h1c10_1000_2c02, 48'h1d30_1108_6d03};
    logic [7:0] p, m, o, s, f, c;
    for (int i = 0; i < 6; i++)
    begin
      {p, m, o, s, f, c} = rows[i];
      u_host.script(p, m, o, s, f, c);
      repeat (3) @(posedge i_mclk);
      #1 chk(outs, {{3{p == 8'h1c}}, m == 8'h20, m == 8'h20, m == 8'h10, {2{o == 8'h10}},
        s inside {8'h00, 8'h04}, s == 8'h00, s == 8'h04, s inside {8'h00, 8'h04}, 1'b1,
        f == 8'h6c && m == 8'h10, f == 8'h2c, f == 8'h2c && c == 8'h02});
    end
    $display("scripts done");
  endtask
  task automatic t_reset;
    @(posedge i_mclk);
    i_sys_rst <= 1'h1;
    repeat (3) @(posedge i_mclk);
    #1 chk(outs, 16'h0000);
    repeat (17) @(posedge i_mclk);
    i_sys_rst <= 1'h0;
    repeat (2) @(posedge i_mclk);
    #1 chk(outs, 16'h00d0);
    u_host.rd(8'h30, rv);
    chk_rd(rv, 8'h00);
    $display("reset done");
  endtask
  initial
  begin
    i_sys_rst = 1'b1;
    n_fail = 0;
    compares = 0;
    repeat (20) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    t_regs();
    t_scripts();
    t_reset();
    conclude();
  end
endmodule // edcfg_bank_tb
